// >>> rtl/sbk_brake_ctrl.sv
// Purpose: Holding-brake interlock, servo-off delay and stop-method choice.
// Assumes: Pin inputs are asynchronous; speed inputs come from mclk logic.
// Notes:   Terminal outputs are active-high "function asserted" levels.
//
// Behaviour
// - Brake output low releases the brake, high engages the holding brake.
// - Terminal-select digit 1..6 routes the brake output to that terminal.
// - Terminal-select zero drives the brake output on no terminal.
// - A terminal shows the OR of every function assigned to it.
// - Brake engages the moment servo-on goes to servo-off by default.
// - Motor stays energised for a delay of 0..500 after engaging.
// - Alarm de-energises the motor at once, ignoring the delay.
// - Alarm during rotation stops motor, then engages brake at set speed.
// - Speed threshold above the motor maximum is clipped to the maximum.
// - Stop digit 0 decelerates with torque limit then coasts; 1 coasts.
// - Chosen servo-off method applies on servo-off only; main power off always decelerates.
// - Power loss forces a decelerating stop whatever the setting.
// - Alarm stops the motor by coasting, de-energised.
// - Stop torque limit is 0..300 percent, factory value 300.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
module sbk_brake_ctrl (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Drive status pins
   input  wire logic        servo_on_in,
   input  wire logic        main_power_ok,
   input  wire logic        ctrl_power_ok,
   input  wire logic        alarm_in,
   // Speed feedback from the motion loop
   input  wire logic [15:0] motor_speed,
   input  wire logic [15:0] motor_max_speed,
   input  wire logic        rotation_detect_out,
   // Motor command outputs
   output logic             motor_energise,
   output logic             decel_active,
   output logic [8:0]       stop_torque_limit,
   output logic             brake_release_out,
   output logic [5:0]       out_term,
   output logic             irq
);
   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   // Each pin has its own two-stage chain; only the second stage is read.
   // Power pins reset as lost, so nothing can run before the supplies are seen.
   logic [3:0] pin_raw;
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   assign pin_raw = {alarm_in, ctrl_power_ok, main_power_ok, servo_on_in};
   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_sync
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               pin_s1_q[p] <= 1'b0;
               pin_s2_q[p] <= 1'b0;
            end else begin
               pin_s1_q[p] <= pin_raw[p];
               pin_s2_q[p] <= pin_s1_q[p];
            end
         end
      end
   endgenerate
   logic son;
   logic pwr_ok;
   logic alarm;
   assign son    = pin_s2_q[0];
   assign pwr_ok = pin_s2_q[1] & pin_s2_q[2];
   assign alarm  = pin_s2_q[3];

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   logic        stop_coast_q;
   logic [3:0]  route_q;
   logic [8:0]  off_dly_q;
   logic [15:0] spd_thr_q;
   logic [8:0]  trq_lim_q;
   logic [5:0]  other_out_q;
   logic [2:0]  irq_mask_q;
   // Out-of-range delay and torque-limit writes saturate, so neither passes its top value.
   function automatic logic [8:0] sat9(input logic [31:0] v, input logic [8:0] top);
      sat9 = (v > {23'h0, top}) ? top : v[8:0];
   endfunction : sat9
   // One process per register keeps a decode slip from touching the others.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stop_coast_q <= 1'b0;
      end else if (reg_wr && reg_addr == sbk_pkg::ADDR_CTRL) begin
         stop_coast_q <= reg_wdata[sbk_pkg::CTRL_STOP_BIT];
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         route_q <= sbk_pkg::ROUTE_RST;
      end else if (reg_wr && reg_addr == sbk_pkg::ADDR_ROUTE) begin
         route_q <= reg_wdata[3:0];
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         off_dly_q <= sbk_pkg::OFF_DLY_RST;
      end else if (reg_wr && reg_addr == sbk_pkg::ADDR_OFF_DLY) begin
         off_dly_q <= sat9(reg_wdata, sbk_pkg::OFF_DLY_MAX);
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         spd_thr_q <= sbk_pkg::SPD_THR_RST;
      end else if (reg_wr && reg_addr == sbk_pkg::ADDR_SPD_THR) begin
         spd_thr_q <= reg_wdata[15:0];
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         trq_lim_q <= sbk_pkg::TRQ_LIM_RST;
      end else if (reg_wr && reg_addr == sbk_pkg::ADDR_TRQ_LIM) begin
         trq_lim_q <= sat9(reg_wdata, sbk_pkg::TRQ_LIM_MAX);
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_mask_q <= 3'h0;
      end else if (reg_wr && reg_addr == sbk_pkg::ADDR_IRQ_MASK) begin
         irq_mask_q <= reg_wdata[2:0];
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         other_out_q <= 6'h00;
      end else if (reg_wr && reg_addr == sbk_pkg::ADDR_OTHER_OUT) begin
         other_out_q <= reg_wdata[5:0];
      end
   end
   assign stop_torque_limit = trq_lim_q;

   // ----------------------------------------------------------------------
   // Millisecond tick
   // ----------------------------------------------------------------------
   // The divider runs free, so the first delay step may be up to one tick
   // short; the delay is therefore accurate to within one millisecond.
   logic [16:0] tick_cnt_q;
   logic        tick;
   assign tick = (tick_cnt_q == sbk_pkg::TICK_LAST);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= 17'h00000;
      end else begin
         tick_cnt_q <= tick ? 17'h00000 : tick_cnt_q + 17'h00001;
      end
   end

   // ----------------------------------------------------------------------
   // Brake interlock
   // ----------------------------------------------------------------------
   // A speed threshold above what the motor can reach is never crossed, so
   // it is clipped to the motor maximum.
   logic [15:0] eff_thr;
   assign eff_thr = (spd_thr_q > motor_max_speed) ? motor_max_speed : spd_thr_q;
   logic over_thr;
   assign over_thr = motor_speed > eff_thr;

   logic engage_q;
   logic engage_d;
   logic alarm_run_q;
   // Servo-on releases the brake only with no alarm and both supplies present.
   always_comb begin
      engage_d = engage_q;
      if (son && !alarm && pwr_ok) begin
         engage_d = 1'b0;
      end else if (alarm && over_thr) begin
         // Hold release while still above the threshold after an alarm.
         engage_d = engage_q;
      end else begin
         engage_d = 1'b1;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         engage_q    <= 1'b1;
         alarm_run_q <= 1'b0;
      end else begin
         engage_q    <= engage_d;
         alarm_run_q <= alarm && over_thr;
      end
   end
   // Low means release, high means hold.
   assign brake_release_out = engage_q;

   // Servo-off delay counts ticks from the engage edge.
   logic [8:0] dly_cnt_q;
   logic       dly_done_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dly_cnt_q  <= 9'h000;
         dly_done_q <= 1'b1;
      end else if (!engage_q) begin
         dly_cnt_q  <= 9'h000;
         dly_done_q <= 1'b0;
      end else if (!dly_done_q) begin
         if (dly_cnt_q >= off_dly_q) begin
            dly_done_q <= 1'b1;
         end else if (tick) begin
            dly_cnt_q <= dly_cnt_q + 9'h001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Stop method
   // ----------------------------------------------------------------------
   sbk_pkg::sbk_stop_t stop_q;
   // Servo-on is honoured only with power present; a stop in progress is
   // abandoned at once when both come back.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stop_q <= sbk_pkg::SBK_COAST;
      end else if (alarm) begin
         stop_q <= sbk_pkg::SBK_COAST;
      end else begin
         unique case (stop_q)
            sbk_pkg::SBK_RUN: begin
               if (!pwr_ok) begin
                  stop_q <= sbk_pkg::SBK_DECEL;
               end else if (!son) begin
                  stop_q <= stop_coast_q ? sbk_pkg::SBK_COAST : sbk_pkg::SBK_DECEL;
               end
            end
            sbk_pkg::SBK_DECEL: begin
               // The decelerating stop must end on power loss too, or the motor
               // would stay energised at standstill until power came back.
               if (son && pwr_ok) begin
                  stop_q <= sbk_pkg::SBK_RUN;
               end else if (motor_speed == 16'h0000) begin
                  stop_q <= sbk_pkg::SBK_COAST;
               end
            end
            sbk_pkg::SBK_COAST: begin
               if (son && pwr_ok) begin
                  stop_q <= sbk_pkg::SBK_RUN;
               end
            end
            default: stop_q <= sbk_pkg::SBK_COAST;
         endcase
      end
   end
   // Motor stays energised through the run, the decel and the brake delay,
   // but an alarm cuts it regardless of the delay.
   assign motor_energise = !alarm &&
                           (stop_q == sbk_pkg::SBK_RUN || stop_q == sbk_pkg::SBK_DECEL ||
                            !dly_done_q);
   assign decel_active   = (stop_q == sbk_pkg::SBK_DECEL) && !alarm;

   // ----------------------------------------------------------------------
   // Output terminal routing
   // ----------------------------------------------------------------------
   // The brake level is ORed with other functions; sharing a terminal with
   // a bit set in the other-output register can pin it high and defeat the brake timing.
   // Route values above six match no terminal, so they act like zero.
   genvar t;
   generate
      for (t = 0; t < sbk_pkg::NUM_TERM; t++) begin : g_term
         logic sel;
         assign sel = (route_q == 4'(t + 1));
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               out_term[t] <= 1'b0;
            end else begin
               out_term[t] <= (sel & engage_q) | other_out_q[t];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------
   logic [2:0] irq_stat_q;
   logic [2:0] ev;
   logic       alarm_d1_q;
   logic       pwr_d1_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         alarm_d1_q <= 1'b0;
         pwr_d1_q   <= 1'b0;
      end else begin
         alarm_d1_q <= alarm;
         pwr_d1_q   <= pwr_ok;
      end
   end
   // Edges come from the synchronised levels, so a pin pulse shorter than a
   // clock cycle may be missed.
   assign ev[sbk_pkg::IRQ_ENGAGE]   = engage_d & ~engage_q;
   assign ev[sbk_pkg::IRQ_ALARM]    = alarm & ~alarm_d1_q;
   assign ev[sbk_pkg::IRQ_PWR_LOSS] = pwr_d1_q & ~pwr_ok;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_q <= 3'h0;
      end else begin
         // A new event wins over a write-one-to-clear in the same cycle.
         irq_stat_q <= (irq_stat_q &
                       ~((reg_wr && reg_addr == sbk_pkg::ADDR_IRQ_STAT) ? reg_wdata[2:0] : 3'h0))
                       | ev;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   // The status fields are gathered into one word so a read sees one cycle.
   logic [31:0] status_word;
   assign status_word = {24'h0, alarm_run_q, rotation_detect_out, stop_q, dly_done_q,
                         motor_energise, engage_q, son};
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            sbk_pkg::ADDR_CTRL:      reg_rdata <= {31'h0, stop_coast_q};
            sbk_pkg::ADDR_ROUTE:     reg_rdata <= {28'h0, route_q};
            sbk_pkg::ADDR_OFF_DLY:   reg_rdata <= {23'h0, off_dly_q};
            sbk_pkg::ADDR_SPD_THR:   reg_rdata <= {16'h0, spd_thr_q};
            sbk_pkg::ADDR_TRQ_LIM:   reg_rdata <= {23'h0, trq_lim_q};
            sbk_pkg::ADDR_STATUS:    reg_rdata <= status_word;
            sbk_pkg::ADDR_IRQ_STAT:  reg_rdata <= {29'h0, irq_stat_q};
            sbk_pkg::ADDR_IRQ_MASK:  reg_rdata <= {29'h0, irq_mask_q};
            sbk_pkg::ADDR_OTHER_OUT: reg_rdata <= {26'h0, other_out_q};
            default:                 reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule : sbk_brake_ctrl

// >>> rtl/sbk_pkg.sv
// Purpose: Constants for the brake interlock and stop-method block.
// Assumes: 100 MHz mclk; the delay setting unit is one millisecond tick.
// Notes:   Register offsets index 32-bit words on the plain register port.
package sbk_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_ROUTE     = 4'h1;
   localparam logic [3:0]  ADDR_OFF_DLY   = 4'h2;
   localparam logic [3:0]  ADDR_SPD_THR   = 4'h3;
   localparam logic [3:0]  ADDR_TRQ_LIM   = 4'h4;
   localparam logic [3:0]  ADDR_STATUS    = 4'h5;
   localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h6;
   localparam logic [3:0]  ADDR_IRQ_MASK  = 4'h7;
   localparam logic [3:0]  ADDR_OTHER_OUT = 4'h8;
   // ----------------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------------
   localparam int          CTRL_STOP_BIT  = 0;
   localparam logic [3:0]  ROUTE_RST      = 4'h0;
   localparam int          NUM_TERM       = 6;
   localparam logic [8:0]  OFF_DLY_MAX    = 9'h1f4;
   localparam logic [8:0]  OFF_DLY_RST    = 9'h000;
   localparam logic [8:0]  TRQ_LIM_MAX    = 9'h12c;
   localparam logic [8:0]  TRQ_LIM_RST    = 9'h12c;
   localparam logic [15:0] SPD_THR_RST    = 16'h0064;
   localparam int          IRQ_W          = 3;
   localparam int          IRQ_ENGAGE     = 0;
   localparam int          IRQ_ALARM      = 1;
   localparam int          IRQ_PWR_LOSS   = 2;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int          CLK_HZ         = 100_000_000;
   localparam int          TICK_US        = 1000;
   localparam int          TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
   localparam logic [16:0] TICK_LAST      = 17'(TICK_CYC - 1);
   // Stop-method states.
   typedef enum logic [1:0] {SBK_RUN, SBK_DECEL, SBK_COAST} sbk_stop_t;
endpackage : sbk_pkg

// >>> sim/sbk_brake_chk_sva.sv
// Purpose: Port-level assertions for the brake interlock and stop-method block.
// Assumes: Pin inputs pass a two-stage synchroniser before the logic acts on them.
// Notes:   Bound to every instance of sbk_brake_ctrl.
`timescale 1ns/100ps
module sbk_brake_chk (
   // Clock, reset and inputs
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        reg_rd,
   input wire logic        servo_on_in,
   input wire logic        main_power_ok,
   input wire logic        alarm_in,
   input wire logic [15:0] motor_speed,
   input wire logic [15:0] motor_max_speed,
   // Outputs
   input wire logic [31:0] reg_rdata,
   input wire logic        motor_energise,
   input wire logic        decel_active,
   input wire logic [8:0]  stop_torque_limit,
   input wire logic        brake_release_out,
   input wire logic [5:0]  out_term
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_reset_safe: assert property ($rose(resetn) |-> brake_release_out && out_term == 6'h00)
      else $error("brake or terminal active after reset");
   a_off_engage: assert property ((!servo_on_in && !alarm_in) [*6] |-> brake_release_out)
      else $error("brake not engaged after servo off");
   a_alarm_coast: assert property (alarm_in [*5] |-> !motor_energise && !decel_active)
      else $error("motor powered during alarm");
   a_decel_powered: assert property (decel_active |-> motor_energise)
      else $error("decelerating while de-energised");
   a_power_decel:
      assert property ($fell(main_power_ok) && motor_energise && !decel_active && !alarm_in
         && motor_speed != 16'h0000 |-> ##[1:5] decel_active) else $error("no power-loss stop");
   a_hold_fast:
      assert property (!brake_release_out ##1 (alarm_in && motor_speed > motor_max_speed) [*6]
         |-> !brake_release_out) else $error("brake engaged while still fast");
   a_stop_engage:
      assert property ((alarm_in && motor_speed == 16'h0000) [*6] |-> brake_release_out)
         else $error("brake not engaged after alarm stop");
   a_torque_range: assert property (stop_torque_limit <= sbk_pkg::TRQ_LIM_MAX)
      else $error("stop torque limit above range");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   cover property (decel_active ##1 !decel_active);
   cover property ($rose(brake_release_out));
   cover property (alarm_in && !brake_release_out);
endmodule : sbk_brake_chk

bind sbk_brake_ctrl sbk_brake_chk sbk_brake_chk_i (.mclk(mclk), .resetn(resetn),
   .reg_rd(reg_rd), .servo_on_in(servo_on_in), .main_power_ok(main_power_ok),
   .alarm_in(alarm_in), .motor_speed(motor_speed), .motor_max_speed(motor_max_speed),
   .reg_rdata(reg_rdata), .motor_energise(motor_energise), .decel_active(decel_active),
   .stop_torque_limit(stop_torque_limit), .brake_release_out(brake_release_out),
   .out_term(out_term));

// >>> sim/sbk_relay_model.sv
// Purpose: Brake relay wired to one output terminal of the drive.
// Assumes: The coil picks up, releasing the brake, while its terminal reads low.
// Notes:   Pick-up takes one mclk; a real relay is far slower.
`timescale 1ns/100ps
module sbk_relay_model (
   // Clock
   input  wire logic       mclk,
   // Drive terminals and wiring
   input  wire logic [5:0] out_term,
   input  wire logic [2:0] wire_sel,
   // Relay contact
   output logic            brake_released
);
   // The relay reads its terminal level alone, so any other function ORed onto that terminal also holds it high.
   always_ff @(posedge mclk) begin
      brake_released <= !out_term[wire_sel - 3'h1];
   end
endmodule : sbk_relay_model

// >>> sim/tb_top.sv
// Purpose: Directed bench for the brake interlock and stop-method block.
// Assumes: Off-delay kept at zero, since one delay step is a whole millisecond.
// Notes:   Scenarios run in order and share the register and wait tasks.
`timescale 1ns/100ps
module tb_top;
   logic        mclk, resetn, reg_wr, reg_rd, son, mpo, cpo, alm, rot;
   logic        men, dec, brk, irq, rel;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, rdata;
   logic [15:0] spd, smax;
   logic [8:0]  trq;
   logic [5:0]  term;
   int          n_fail = 0;
   int          n_tests = 0;

   sbk_brake_ctrl sbk_brake_ctrl_i (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
      .servo_on_in(son), .main_power_ok(mpo), .ctrl_power_ok(cpo), .alarm_in(alm),
      .motor_speed(spd), .motor_max_speed(smax), .rotation_detect_out(rot),
      .motor_energise(men), .decel_active(dec), .stop_torque_limit(trq),
      .brake_release_out(brk), .out_term(term), .irq(irq));
   sbk_relay_model sbk_relay_model_i (.mclk(mclk), .out_term(term), .wire_sel(3'h3),
      .brake_released(rel));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are taken just after it.
   task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 chk(rdata & m, e);
   endtask : rd

   task automatic wt(ref logic s, input logic v);
      #1;
      for (int i = 0; i < 40 && s !== v; i++) begin
         @(posedge mclk);
         #1;
      end
      if (s !== v) begin
         n_fail++;
         report_and_stop;
      end
      chk(32'(s), 32'(v));
   endtask : wt

   task t_regs;
      chk(32'(brk), 32'h1);
      chk(32'(term), 32'h0);
      chk(32'(trq), 32'h12c);
      rd(sbk_pkg::ADDR_ROUTE, 32'hf, 32'h0);
      rd(4'hf, 32'hffffffff, 32'h0);
      wr(sbk_pkg::ADDR_TRQ_LIM, 32'h1ff);
      rd(sbk_pkg::ADDR_TRQ_LIM, 32'h1ff, 32'h12c);
      wr(sbk_pkg::ADDR_TRQ_LIM, 32'h64);
      #1 chk(32'(trq), 32'h64);
      rd(sbk_pkg::ADDR_SPD_THR, 32'hffff, 32'h64);
      wr(sbk_pkg::ADDR_SPD_THR, 32'h28);
      rd(sbk_pkg::ADDR_SPD_THR, 32'hffff, 32'h28);
      wr(sbk_pkg::ADDR_SPD_THR, 32'h64);
      wr(sbk_pkg::ADDR_OFF_DLY, 32'h3ff);
      rd(sbk_pkg::ADDR_OFF_DLY, 32'h1ff, 32'h1f4);
      wr(sbk_pkg::ADDR_OFF_DLY, 32'h0);
      for (int r = 0; r <= 6; r++) begin
         wr(sbk_pkg::ADDR_ROUTE, 32'(r));
         repeat (2) @(posedge mclk);
         #1 chk(32'(term), (r == 0) ? 32'h0 : 32'h1 << (r - 1));
      end
      wr(sbk_pkg::ADDR_OTHER_OUT, 32'h1);
      repeat (2) @(posedge mclk);
      #1 chk(32'(term), 32'h21);
      wr(sbk_pkg::ADDR_OTHER_OUT, 32'h0);
      wr(sbk_pkg::ADDR_ROUTE, 32'h3);
      $display("registers and routing done");
   endtask : t_regs

   // Start the motor with the given stop method, then take servo away.
   task run_then_off(input logic [31:0] method, input logic [15:0] speed);
      wr(sbk_pkg::ADDR_CTRL, method);
      @(posedge mclk) son <= 1'b1;
      spd <= speed;
      wt(brk, 1'b0);
      wt(rel, 1'b1);
      chk(32'(men), 32'h1);
      @(posedge mclk) son <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 chk(32'(brk), 32'h1);
   endtask : run_then_off

   task t_coast;
      wr(sbk_pkg::ADDR_IRQ_MASK, 32'h7);
      run_then_off(32'h1, 16'h0);
      chk(32'(dec), 32'h0);
      wt(men, 1'b0);
      chk(32'(irq), 32'h1);
      rd(sbk_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
      wr(sbk_pkg::ADDR_IRQ_STAT, 32'h7);
      rd(sbk_pkg::ADDR_IRQ_STAT, 32'h7, 32'h0);
      chk(32'(irq), 32'h0);
      run_then_off(32'h0, 16'h00c8);
      wt(dec, 1'b1);
      chk(32'(men), 32'h1);
      @(posedge mclk) spd <= 16'h0;
      wt(dec, 1'b0);
      wt(men, 1'b0);
      $display("servo off stop methods done");
   endtask : t_coast

   task t_power;
      wr(sbk_pkg::ADDR_CTRL, 32'h1);
      @(posedge mclk) son <= 1'b1;
      spd <= 16'h00c8;
      wt(brk, 1'b0);
      @(posedge mclk) mpo <= 1'b0;
      wt(dec, 1'b1);
      rd(sbk_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
      @(posedge mclk) spd <= 16'h0;
      wt(men, 1'b0);
      @(posedge mclk) son <= 1'b0;
      mpo <= 1'b1;
      wr(sbk_pkg::ADDR_IRQ_STAT, 32'h7);
      $display("power loss done");
   endtask : t_power

   // Threshold stays 100 while the motor maximum is 50, so 60 must still hold the brake off.
   task t_alarm;
      wr(sbk_pkg::ADDR_CTRL, 32'h0);
      @(posedge mclk) son <= 1'b1;
      spd  <= 16'h00c8;
      smax <= 16'h0032;
      wt(brk, 1'b0);
      @(posedge mclk) alm <= 1'b1;
      wt(men, 1'b0);
      chk(32'(dec), 32'h0);
      @(posedge mclk) spd <= 16'h003c;
      rot <= 1'b1;
      repeat (8) @(posedge mclk);
      #1 chk(32'(brk), 32'h0);
      rd(sbk_pkg::ADDR_STATUS, 32'hc0, 32'hc0);
      @(posedge mclk) spd <= 16'h0;
      rot <= 1'b0;
      wt(brk, 1'b1);
      wr(sbk_pkg::ADDR_IRQ_MASK, 32'h4);
      #1 chk(32'(irq), 32'h0);
      wr(sbk_pkg::ADDR_IRQ_MASK, 32'h2);
      #1 chk(32'(irq), 32'h1);
      wr(sbk_pkg::ADDR_IRQ_STAT, 32'h2);
      #1 chk(32'(irq), 32'h0);
      @(posedge mclk) alm <= 1'b0;
      son <= 1'b0;
      $display("alarm stop done");
   endtask : t_alarm

   initial begin
      resetn    = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 32'h0;
      {son, alm, rot} = 3'h0;
      {mpo, cpo} = 2'h3;
      spd  = 16'h0;
      smax = 16'h0bb8;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      #1 t_regs;
      t_coast;
      t_power;
      t_alarm;
      report_and_stop;
   end
endmodule : tb_top
